// file: src/lmd_pkg.sv
// Shared constants, state encoding and pin decode for the display
// driver's two-wire slave port.
// Assumes one system clock; all bus pins are asynchronous to it.
package lmd_pkg;

    // ========================================================
    // Address, pointer and bit counter constants
    localparam logic [2:0] ADDR_TOP = 3'h5;
    localparam logic [6:0] CMD_FONT = 7'h05;
    localparam logic [6:0] CMD_LAST = 7'h7F;
    localparam logic [6:0] CMD_RST  = 7'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_RST  = 3'h0;

    // ========================================================
    // Address pin strap codes
    localparam logic [1:0] PIN_GND = 2'h0;
    localparam logic [1:0] PIN_VDD = 2'h1;
    localparam logic [1:0] PIN_SDA = 2'h2;
    localparam logic [1:0] PIN_SCL = 2'h3;

    // ========================================================
    // Buffer defaults
    localparam int FIFO_DEPTH = 8;
    localparam int FONT_W     = 7;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_CMD, ST_CACK,
        ST_WDATA, ST_WACK, ST_RDATA, ST_RACK, ST_IGNORE
    } lmd_state_e;

    // Level seen with bus idle, at START, and at first SCL fall
    function automatic logic [1:0] lmd_pin_code(input logic idle,
                                                input logic strt,
                                                input logic fall);
        logic [1:0] c;
        c = PIN_VDD;
        if (!idle) c = PIN_GND;
        else if (!strt) c = PIN_SDA;
        else if (!fall) c = PIN_SCL;
        return c;
    endfunction : lmd_pin_code

endpackage : lmd_pkg

// file: src/lmd_i2c_slave.sv
// Two-wire slave port of the LED matrix driver, with its write FIFO.
// Assumes SCL and SDA arrive asynchronous to mclk and much slower.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Shift-register FIFO; head word sits in entry 0
module lmd_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [CW-1:0]           count;
        logic                    nonempty;
        logic                    full;
    } lmd_fifo_s;

    lmd_fifo_s st;
    lmd_fifo_s next_st;

    always_comb begin
        logic          pop;
        logic          push;
        logic [CW-1:0] base;
        pop     = st.nonempty && out_ready;
        push    = in_valid && !st.full;
        base    = st.count - CW'(pop);
        next_st = st;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_st.mem[i] = st.mem[i+1];
            end
        end
        if (push) begin
            next_st.mem[base] = in_data;
        end
        next_st.count    = base + CW'(push);
        next_st.nonempty = next_st.count != '0;
        next_st.full     = next_st.count == CW'(DEPTH);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready  = !st.full;
    assign out_valid = st.nonempty;
    assign out_data  = st.mem[0];
endmodule : lmd_fifo

// ============================================================
// Bus slave: framing, address match, pointer, read and write
module lmd_i2c_slave
    import lmd_pkg::*;
#(
    parameter int FW    = FONT_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          scl_in,
    input  wire logic          sda_in,
    output logic               sda_out,
    output logic               sda_oe,
    input  wire logic          addr_select_pin_low,
    input  wire logic          addr_select_pin_high,
    output logic [6:0]         rd_addr,
    output logic [FW-1:0]      rd_font,
    input  wire logic [7:0]    rd_data,
    output logic               wr_valid,
    input  wire logic          wr_ready,
    output logic [6:0]         wr_cmd,
    output logic [FW-1:0]      wr_font,
    output logic [7:0]         wr_data,
    output logic               bus_busy
);
    localparam int WW = 7 + FW + 8;

    typedef struct packed {
        logic          scl_m, scl_s, scl_q;
        logic          sda_m, sda_s, sda_q;
        logic          psl_m, psl_s, psh_m, psh_s;
        logic [1:0]    pin_idle, pin_start, pin_fall;
        logic          first_fall;
        lmd_state_e    state;
        logic [2:0]    bits;
        logic [7:0]    shift;
        logic [7:0]    tx;
        logic          rw, mack, acked, busy;
        logic          drv, sda_lo;
        logic [6:0]    ptr;
        logic [FW-1:0] font;
        logic          push;
        logic [WW-1:0] wdata;
    } lmd_top_s;

    lmd_top_s st;
    lmd_top_s next_st;

    logic       start;
    logic       stop;
    logic       rise;
    logic       fall;
    logic       match;
    logic       last;
    logic       adv;
    logic       fifo_ready;
    logic [3:0] strap;

    // ========================================================
    // Bus event decode on synchronised samples
    assign rise  = st.scl_s && !st.scl_q;
    assign fall  = !st.scl_s && st.scl_q;
    assign start = st.scl_s && st.scl_q && st.sda_q && !st.sda_s;
    assign stop  = st.scl_s && st.scl_q && !st.sda_q && st.sda_s;
    assign last  = st.bits == BIT_LAST;
    assign strap = {lmd_pin_code(st.pin_idle[1], st.pin_start[1], st.pin_fall[1]),
                    lmd_pin_code(st.pin_idle[0], st.pin_start[0], st.pin_fall[0])};
    assign match = st.shift[7:5] == ADDR_TOP && st.shift[4:1] == strap;
    assign adv   = fall && last && ((st.state == ST_WDATA && fifo_ready)
                                    || st.state == ST_RDATA);

    // ========================================================
    // Next state
    always_comb begin
        logic [6:0]    ptr_nx;
        logic [FW-1:0] font_nx;
        ptr_nx  = st.ptr;
        font_nx = st.font;
        next_st = st;
        next_st.scl_m = scl_in;
        next_st.scl_s = st.scl_m;
        next_st.scl_q = st.scl_s;
        next_st.sda_m = sda_in;
        next_st.sda_s = st.sda_m;
        next_st.sda_q = st.sda_s;
        next_st.psl_m = addr_select_pin_low;
        next_st.psl_s = st.psl_m;
        next_st.psh_m = addr_select_pin_high;
        next_st.psh_s = st.psh_m;
        next_st.push  = 1'b0;
        if (st.ptr == CMD_FONT) begin
            font_nx = st.font + 1'b1;
        end else if (st.ptr != CMD_LAST) begin
            ptr_nx = st.ptr + 7'h01;
        end
        if (st.scl_s && st.sda_s && !st.busy) begin
            next_st.pin_idle = {st.psh_s, st.psl_s};
        end
        if (start) begin
            next_st.state      = ST_ADDR;
            next_st.bits       = BIT_RST;
            next_st.drv        = 1'b0;
            next_st.busy       = 1'b1;
            next_st.first_fall = 1'b1;
            next_st.pin_start  = {st.psh_s, st.psl_s};
        end else if (stop) begin
            next_st.state = ST_IDLE;
            next_st.drv   = 1'b0;
            next_st.busy  = 1'b0;
        end else if (rise) begin
            if (st.state inside {ST_ADDR, ST_CMD, ST_WDATA}) begin
                next_st.shift = {st.shift[6:0], st.sda_s};
            end
            if (st.state == ST_RACK) begin
                next_st.mack = !st.sda_s;
            end
        end else if (fall && st.first_fall) begin
            next_st.first_fall = 1'b0;
            next_st.pin_fall   = {st.psh_s, st.psl_s};
        end else if (fall) begin
            unique case (st.state)
                ST_ADDR: begin
                    if (last) begin
                        next_st.rw = st.shift[0];
                        if (match) begin
                            next_st.drv   = 1'b1;
                            next_st.state = ST_AACK;
                        end else begin
                            next_st.state = ST_IGNORE;
                        end
                    end else begin
                        next_st.bits = st.bits + 3'h1;
                    end
                end
                ST_AACK: begin
                    next_st.bits = BIT_RST;
                    if (st.rw) begin
                        next_st.tx    = rd_data;
                        next_st.drv   = !rd_data[7];
                        next_st.state = ST_RDATA;
                    end else begin
                        next_st.drv   = 1'b0;
                        next_st.state = ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (last) begin
                        next_st.ptr   = st.shift[6:0];
                        next_st.drv   = 1'b1;
                        next_st.state = ST_CACK;
                    end else begin
                        next_st.bits = st.bits + 3'h1;
                    end
                end
                ST_CACK: begin
                    next_st.drv   = 1'b0;
                    next_st.bits  = BIT_RST;
                    next_st.state = ST_WDATA;
                end
                ST_WDATA: begin
                    if (last) begin
                        next_st.state = ST_WACK;
                        next_st.acked = fifo_ready;
                        if (fifo_ready) begin
                            next_st.push  = 1'b1;
                            next_st.wdata = {st.ptr, st.font, st.shift};
                            next_st.drv   = 1'b1;
                            next_st.ptr   = ptr_nx;
                            next_st.font  = font_nx;
                        end
                    end else begin
                        next_st.bits = st.bits + 3'h1;
                    end
                end
                ST_WACK: begin
                    next_st.drv   = 1'b0;
                    next_st.bits  = BIT_RST;
                    next_st.state = st.acked ? ST_WDATA : ST_IGNORE;
                end
                ST_RDATA: begin
                    if (last) begin
                        next_st.drv   = 1'b0;
                        next_st.state = ST_RACK;
                        next_st.ptr   = ptr_nx;
                        next_st.font  = font_nx;
                    end else begin
                        next_st.tx   = {st.tx[6:0], 1'b0};
                        next_st.drv  = !st.tx[6];
                        next_st.bits = st.bits + 3'h1;
                    end
                end
                ST_RACK: begin
                    next_st.bits = BIT_RST;
                    if (st.mack) begin
                        next_st.tx    = rd_data;
                        next_st.drv   = !rd_data[7];
                        next_st.state = ST_RDATA;
                    end else begin
                        next_st.state = ST_IGNORE;
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    next_st.drv = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st       <= '0;
            st.scl_m <= 1'b1;
            st.scl_s <= 1'b1;
            st.scl_q <= 1'b1;
            st.sda_m <= 1'b1;
            st.sda_s <= 1'b1;
            st.sda_q <= 1'b1;
            st.state <= ST_IDLE;
            st.ptr   <= CMD_RST;
        end else begin
            st <= next_st;
        end
    end

    // ========================================================
    // Write data buffer
    lmd_fifo #(
        .W     (WW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (st.push),
        .in_ready  (fifo_ready),
        .in_data   (st.wdata),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  ({wr_cmd, wr_font, wr_data})
    );

    assign sda_out  = st.sda_lo;
    assign sda_oe   = st.drv;
    assign rd_addr  = st.ptr;
    assign rd_font  = st.font;
    assign bus_busy = st.busy;

    // ========================================================
    // Checks
    property p_oe_rise;
        @(posedge mclk) disable iff (rst)
        $rose(sda_oe) |-> !st.scl_s;
    endproperty
    a_oe_rise: assert property (p_oe_rise)
        else $error("SDA drive began while SCL high");

    property p_oe_hold;
        @(posedge mclk) disable iff (rst)
        st.scl_s && $past(st.scl_s) && !$past(stop) |-> $stable(sda_oe);
    endproperty
    a_oe_hold: assert property (p_oe_hold)
        else $error("SDA drive changed during SCL high");

    property p_start;
        @(posedge mclk) disable iff (rst)
        start |=> st.state == ST_ADDR && st.bits == BIT_RST && !sda_oe;
    endproperty
    a_start: assert property (p_start)
        else $error("START did not restart the receiver");

    property p_stop;
        @(posedge mclk) disable iff (rst)
        stop |=> st.state == ST_IDLE && !bus_busy && !sda_oe;
    endproperty
    a_stop: assert property (p_stop)
        else $error("STOP did not free the bus");

    property p_addr_ack;
        @(posedge mclk) disable iff (rst)
        fall && !st.first_fall && st.state == ST_ADDR && last && match
        |=> sda_oe && st.state == ST_AACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("Own address not acknowledged");

    property p_addr_miss;
        @(posedge mclk) disable iff (rst)
        fall && !st.first_fall && st.state == ST_ADDR && last && !match
        |=> !sda_oe && st.state == ST_IGNORE;
    endproperty
    a_addr_miss: assert property (p_addr_miss)
        else $error("Foreign address not ignored");

    property p_cmd_store;
        @(posedge mclk) disable iff (rst)
        fall && !st.first_fall && st.state == ST_CMD && last
        |=> rd_addr == $past(st.shift[6:0]) && sda_oe;
    endproperty
    a_cmd_store: assert property (p_cmd_store)
        else $error("Command byte not stored");

    property p_wr_push;
        @(posedge mclk) disable iff (rst)
        adv && st.state == ST_WDATA
        |=> st.push && st.wdata[7:0] == $past(st.shift)
            && st.wdata[WW-1:WW-7] == $past(st.ptr);
    endproperty
    a_wr_push: assert property (p_wr_push)
        else $error("Data byte not queued at pointer");

    property p_last_hold;
        @(posedge mclk) disable iff (rst)
        adv && st.ptr == CMD_LAST |=> rd_addr == CMD_LAST;
    endproperty
    a_last_hold: assert property (p_last_hold)
        else $error("Top command address advanced");

    property p_font_step;
        @(posedge mclk) disable iff (rst)
        adv && st.ptr == CMD_FONT
        |=> rd_addr == CMD_FONT && rd_font == $past(st.font) + 1'b1;
    endproperty
    a_font_step: assert property (p_font_step)
        else $error("Font pointer step wrong");

    property p_rd_bit;
        @(posedge mclk) disable iff (rst)
        fall && !st.first_fall && st.state == ST_RDATA && !last
        |=> sda_oe == !$past(st.tx[6]);
    endproperty
    a_rd_bit: assert property (p_rd_bit)
        else $error("Read bit driven wrongly");
endmodule : lmd_i2c_slave

`default_nettype wire

// file: testbench/lmd_master.sv
// Behavioural two-wire bus master that drives the slave port under test.
// Assumes the bench resolves the open-drain data wire and feeds it back.
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Master: owns SCL, pulls SDA low only, SCL stands still between frames
module lmd_master (
    input  wire logic mclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // Works from idle and, as a repeated start, from SCL low
    task automatic start();
        tick(1);
        sda_low <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
        @(negedge mclk);
    endtask : start

    task automatic stop();
        tick(1);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
        @(negedge mclk);
    endtask : stop

    // Data changes only while SCL is low
    task automatic bit_io(input logic b, output logic seen);
        tick(1);
        sda_low <= !b;
        tick(3);
        scl <= 1'b1;
        tick(1);
        @(negedge mclk);
        seen = sda;
        tick(3);
        scl <= 1'b0;
    endtask : bit_io

    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask : send

    // Master acknowledges each byte it reads, the last with a release
    task automatic recv(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask : recv
endmodule : lmd_master
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the two-wire slave port and its write FIFO.
// Assumes lmd_pkg and lmd_master are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb
    import lmd_pkg::*;
;
    localparam logic [7:0] DEV_W = {ADDR_TOP, 5'h00};

    logic            mclk;
    logic            rst;
    logic            wr_ready;
    logic [1:0]      strap_lo;
    logic [1:0]      strap_hi;
    wire logic       scl;
    wire logic       sda;
    wire logic       sda_low;
    wire logic       pin_lo;
    wire logic       pin_hi;
    wire logic [7:0] rd_data;
    logic            sda_out;
    logic            sda_oe;
    logic [6:0]      rd_addr;
    logic [6:0]      rd_font;
    logic            wr_valid;
    logic [6:0]      wr_cmd;
    logic [6:0]      wr_font;
    logic [7:0]      wr_data;
    logic            bus_busy;
    int              mismatches;
    int              checks;
    int              cycles;

    // ========================================================
    // Wires, straps and register file stand-in
    assign sda = !(sda_low || sda_oe);
    assign pin_lo = strap_lo == PIN_GND ? 1'b0 : strap_lo == PIN_VDD ? 1'b1 :
                    strap_lo == PIN_SDA ? sda : scl;
    assign pin_hi = strap_hi == PIN_GND ? 1'b0 : strap_hi == PIN_VDD ? 1'b1 :
                    strap_hi == PIN_SDA ? sda : scl;
    assign rd_data = {1'b0, rd_addr} ^ 8'hA5;

    lmd_master mst (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));

    lmd_i2c_slave uut (
        .mclk(mclk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_select_pin_low(pin_lo), .addr_select_pin_high(pin_hi),
        .rd_addr(rd_addr), .rd_font(rd_font), .rd_data(rd_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_cmd(wr_cmd),
        .wr_font(wr_font), .wr_data(wr_data), .bus_busy(bus_busy)
    );

    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    // ========================================================
    // Shared helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            wrap_up();
        end
    end

    task automatic wr_bytes(input logic [7:0] cmd, input int n, input logic [7:0] d0,
                            input int ok_n);
        logic a;
        mst.start();
        chk({7'h00, bus_busy}, 8'h01);
        mst.send(DEV_W, a);
        chk({7'h00, a}, 8'h01);
        mst.send(cmd, a);
        chk({7'h00, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            mst.send(d0 + 8'(i), a);
            chk({7'h00, a}, {7'h00, 1'(i < ok_n)});
        end
        mst.stop();
        chk({7'h00, bus_busy}, 8'h00);
    endtask : wr_bytes

    // Pops one word from the FIFO after comparing it
    task automatic drain(input logic [6:0] c, input logic [6:0] f, input logic [7:0] d);
        int i;
        i = 0;
        @(negedge mclk);
        while (wr_valid !== 1'b1 && i < 50) begin
            @(negedge mclk);
            i++;
        end
        chk({7'h00, wr_valid}, 8'h01);
        chk({1'b0, wr_cmd}, {1'b0, c});
        chk({1'b0, wr_font}, {1'b0, f});
        chk(wr_data, d);
        @(posedge mclk) wr_ready <= 1'b1;
        @(posedge mclk) wr_ready <= 1'b0;
    endtask : drain

    // ========================================================
    // Scenarios
    task automatic t_reset();
        @(negedge mclk);
        chk({7'h00, sda_oe}, 8'h00);
        chk({7'h00, sda_out}, 8'h00);
        chk({7'h00, bus_busy}, 8'h00);
        chk({7'h00, wr_valid}, 8'h00);
        chk({1'b0, rd_addr}, 8'h00);
        chk({1'b0, rd_font}, 8'h00);
    endtask : t_reset

    task automatic t_write();
        wr_bytes(8'h81, 2, 8'hAB, 2);
        chk({1'b0, rd_addr}, 8'h03);
        drain(7'h01, 7'h00, 8'hAB);
        drain(7'h02, 7'h00, 8'hAC);
    endtask : t_write

    task automatic t_cmd_top();
        wr_bytes({1'b0, CMD_LAST}, 0, 8'h00, 0);
        chk({1'b0, rd_addr}, 8'h7F);
        chk({7'h00, wr_valid}, 8'h00);
        wr_bytes({1'b0, CMD_LAST}, 2, 8'h10, 2);
        chk({1'b0, rd_addr}, 8'h7F);
        drain(CMD_LAST, 7'h00, 8'h10);
        drain(CMD_LAST, 7'h00, 8'h11);
    endtask : t_cmd_top

    task automatic t_font();
        wr_bytes({1'b0, CMD_FONT}, 3, 8'h20, 3);
        chk({1'b0, rd_addr}, {1'b0, CMD_FONT});
        chk({1'b0, rd_font}, 8'h03);
        for (int i = 0; i < 3; i++) drain(CMD_FONT, 7'(i), 8'h20 + 8'(i));
    endtask : t_font

    task automatic t_read();
        logic       a;
        logic [7:0] d;
        wr_bytes(8'h10, 0, 8'h00, 0);
        mst.start();
        mst.send({ADDR_TOP, 5'h01}, a);
        chk({7'h00, a}, 8'h01);
        for (int i = 0; i < 3; i++) begin
            mst.recv(i == 2, d);
            chk(d, {1'b0, 7'(7'h10 + i)} ^ 8'hA5);
        end
        mst.stop();
        chk({1'b0, rd_addr}, 8'h13);
        chk({7'h00, sda_oe}, 8'h00);
    endtask : t_read

    task automatic t_foreign();
        logic a;
        mst.start();
        mst.send(DEV_W | 8'h02, a);
        chk({7'h00, a}, 8'h00);
        mst.send(8'h00, a);
        chk({7'h00, a}, 8'h00);
        mst.start();
        mst.send(DEV_W, a);
        chk({7'h00, a}, 8'h01);
        mst.send(8'h33, a);
        mst.stop();
        chk({1'b0, rd_addr}, 8'h33);
    endtask : t_foreign

    task automatic t_straps();
        logic a;
        for (int k = 0; k < 16; k++) begin
            @(posedge mclk);
            strap_hi <= 2'(k >> 2);
            strap_lo <= 2'(k);
            mst.tick(10);
            mst.start();
            mst.send({ADDR_TOP, 2'(k >> 2), 2'(k), 1'b0}, a);
            chk({7'h00, a}, 8'h01);
            mst.stop();
        end
        @(posedge mclk);
        strap_hi <= PIN_GND;
        strap_lo <= PIN_GND;
        mst.tick(10);
    endtask : t_straps

    // Ninth byte finds the FIFO full and is refused
    task automatic t_full();
        wr_bytes(8'h20, 9, 8'h40, 8);
        chk({1'b0, rd_addr}, 8'h28);
        for (int i = 0; i < 8; i++) drain(7'h20 + 7'(i), 7'h03, 8'h40 + 8'(i));
        @(negedge mclk);
        chk({7'h00, wr_valid}, 8'h00);
    endtask : t_full

    // ========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        wr_ready = 1'b0;
        strap_lo = PIN_GND;
        strap_hi = PIN_GND;
        mismatches = 0;
        checks = 0;
        cycles = 0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
        t_reset();
        t_write();
        t_cmd_top();
        t_font();
        t_read();
        t_foreign();
        t_straps();
        t_full();
        wrap_up();
    end
endmodule : tb
`default_nettype wire
